// ==== hdl/trig_pkg.sv ====
// Package for the acquisition trigger control: register map, fields, resets.
// Assumes a 32-bit APB register bus on pclk.
package trig_pkg;
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_LEVEL  = 8'h04;
	localparam logic [7:0] ADDR_POSTCNT = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_IRQ_ST = 8'h10;
	localparam logic [7:0] ADDR_IRQ_MSK = 8'h14;
	localparam logic [7:0] ADDR_SWTRIG = 8'h18;

	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_SRC_LSB  = 4;
	localparam int CTRL_POL_BIT  = 8;
	localparam int CTRL_EN_BIT   = 12;

	localparam int CNT_W   = 16;
	localparam int LEVEL_W = 8;
	localparam int FLAG_BIT = 3;

	localparam logic [CNT_W-1:0]   POSTCNT_RST = 16'h0000;
	localparam logic [LEVEL_W-1:0] LEVEL_RST   = 8'h80;
	localparam logic [2:0]         IRQ_RST     = 3'h0;

	localparam int IRQ_TRIG = 0;
	localparam int IRQ_CAPT = 1;
	localparam int IRQ_DONE = 2;

	typedef enum logic [2:0] {
		mode_software        = 3'b000,
		mode_post            = 3'b001,
		mode_pre             = 3'b010,
		delayed_capture_mode = 3'b011,
		mode_middle          = 3'b100
	} trig_mode_t;

	typedef enum logic [2:0] {
		source_analog_input_0 = 3'b000,
		source_analog_input_1 = 3'b001,
		source_analog_input_2 = 3'b010,
		source_analog_input_3 = 3'b011,
		source_external       = 3'b100
	} trig_src_t;

	typedef enum logic [1:0] {
		st_idle    = 2'b00,
		st_armed   = 2'b01,
		st_counting = 2'b10,
		st_done    = 2'b11
	} acq_state_t;
endpackage

// ==== hdl/slope_detect.sv ====
// Slope detector for one trigger source: compares samples to the level.
// Assumes samples arrive one per clock, synchronous to pclk.
`timescale 1ns/1ns
module slope_detect
	import trig_pkg::*;
#(
	parameter int W = 8
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] sample,
	input  wire logic [W-1:0] level,
	input  wire logic         falling,
	output logic              hit
);
	typedef struct packed {
		logic above;
		logic valid;
	} sd_state_t;

	sd_state_t s_q;
	sd_state_t s_d;
	logic      above_now;

	always_comb begin
		above_now = (sample >= level);
		s_d = s_q;
		s_d.above = above_now;
		s_d.valid = 1'b1;
		// Crossing from below to at/above, or the reverse when falling
		hit = s_q.valid && (falling ? (s_q.above && !above_now)
		                            : (!s_q.above && above_now));
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule

// ==== hdl/trig_ctrl.sv ====
// Acquisition trigger control: mode, source, slope, level, post-trigger counter.
// Assumes APB slave on pclk; samples and external trigger synchronous to pclk.
// Function
// - Five modes: software, post, pre, delayed and middle trigger.
// - Source is analog input 0 to 3 or the external digital input.
// - Polarity 0 fires on rising slope, 1 on falling slope.
// - Analog threshold is an 8-bit level code used by the comparator.
// - Writing the post-trigger count loads the down-counter immediately.
// - After trigger, counter decrements by one each sampling clock edge.
// - Counter stops and holds at zero.
// - Delayed mode: counter sets delay from trigger to capture start.
// - Middle mode: counter sets samples captured after trigger.
// - Each 16-bit sample word carries trigger-detected flag in bit 3.
`timescale 1ns/1ns
module trig_ctrl
	import trig_pkg::*;
#(
	parameter int SAMPLE_W = 16
) (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic [LEVEL_W-1:0]  ain_0,
	input  wire logic [LEVEL_W-1:0]  ain_1,
	input  wire logic [LEVEL_W-1:0]  ain_2,
	input  wire logic [LEVEL_W-1:0]  ain_3,
	input  wire logic                ext_trig,
	input  wire logic [SAMPLE_W-1:0] sample_in,
	output logic      [SAMPLE_W-1:0] sample_out,
	output logic                     capture_en,
	output logic                     irq
);
	typedef struct packed {
		trig_mode_t         mode;
		trig_src_t          src;
		logic               pol;
		logic               enable;
		logic [LEVEL_W-1:0] level;
		logic [CNT_W-1:0]   cnt;
		acq_state_t         state;
		logic               trig_seen;
		logic               ext_prev;
		logic [2:0]         irq_st;
		logic [2:0]         irq_msk;
		logic [31:0]        rdata;
		logic [SAMPLE_W-1:0] sample;
		logic               capture;
	} tc_state_t;

	tc_state_t s_q;
	tc_state_t s_d;

	logic [3:0]         ch_hit;
	logic [LEVEL_W-1:0] ain [4];
	logic               wr;
	logic               rd;
	logic               mapped;
	logic               sw_fire;
	logic               src_hit;
	logic               fire;
	logic [2:0]         ev;

	assign ain[0] = ain_0;
	assign ain[1] = ain_1;
	assign ain[2] = ain_2;
	assign ain[3] = ain_3;

	// One comparator per analog channel keeps history across source changes
	for (genvar i = 0; i < 4; i++) begin : g_ch
		slope_detect #(
			.W(LEVEL_W)
		) u_det (
			.pclk    (pclk),
			.presetn (presetn),
			.sample  (ain[i]),
			.level   (s_q.level),
			.falling (s_q.pol),
			.hit     (ch_hit[i])
		);
	end

	assign wr      = psel && penable && pwrite;
	assign rd      = psel && !penable && !pwrite;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata  = s_q.rdata;
	assign sample_out = s_q.sample;
	assign capture_en = s_q.capture;
	assign irq     = |(s_q.irq_st & s_q.irq_msk);

	always_comb begin
		case (paddr)
			ADDR_CTRL, ADDR_LEVEL, ADDR_POSTCNT, ADDR_STATUS,
			ADDR_IRQ_ST, ADDR_IRQ_MSK, ADDR_SWTRIG: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	assign sw_fire = wr && (paddr == ADDR_SWTRIG) && pwdata[0];

	always_comb begin
		case (s_q.src)
			source_analog_input_0: src_hit = ch_hit[0];
			source_analog_input_1: src_hit = ch_hit[1];
			source_analog_input_2: src_hit = ch_hit[2];
			source_analog_input_3: src_hit = ch_hit[3];
			source_external: src_hit = s_q.pol ? (s_q.ext_prev && !ext_trig)
			                                   : (!s_q.ext_prev && ext_trig);
			default: src_hit = 1'b0;
		endcase
	end

	// Software mode ignores the hardware source entirely
	assign fire = (s_q.mode == mode_software) ? sw_fire : src_hit;

	always_comb begin
		s_d = s_q;
		ev  = 3'b000;
		s_d.ext_prev = ext_trig;

		case (s_q.state)
			st_idle: begin
				s_d.capture = 1'b0;
				if (s_q.enable) begin
					s_d.state     = st_armed;
					s_d.trig_seen = 1'b0;
					// Pre and middle modes record history while waiting
					s_d.capture = (s_q.mode == mode_pre) || (s_q.mode == mode_middle);
				end
			end
			st_armed: begin
				if (!s_q.enable) begin
					s_d.state   = st_idle;
					s_d.capture = 1'b0;
				end else if (fire) begin
					s_d.trig_seen = 1'b1;
					ev[IRQ_TRIG]  = 1'b1;
					case (s_q.mode)
						mode_software, mode_post: begin
							s_d.capture = 1'b1;
							ev[IRQ_CAPT] = 1'b1;
							s_d.state = st_counting;
						end
						mode_pre: begin
							// History ends at the trigger, but the count still runs down
							s_d.capture = 1'b0;
							s_d.state = st_counting;
							ev[IRQ_DONE] = 1'b1;
						end
						delayed_capture_mode: begin
							s_d.capture = 1'b0;
							s_d.state = st_counting;
						end
						mode_middle: begin
							s_d.capture = 1'b1;
							s_d.state = st_counting;
						end
						default: s_d.state = st_idle;
					endcase
				end
			end
			st_counting: begin
				if (!s_q.enable) begin
					s_d.state   = st_idle;
					s_d.capture = 1'b0;
				end else if (s_q.cnt != '0) begin
					s_d.cnt = s_q.cnt - 1'b1;
				end else begin
					// Counter sits at zero; no reload here
					case (s_q.mode)
						delayed_capture_mode: begin
							s_d.capture = 1'b1;
							ev[IRQ_CAPT] = 1'b1;
							s_d.state = st_done;
						end
						mode_middle: begin
							s_d.capture = 1'b0;
							ev[IRQ_DONE] = 1'b1;
							s_d.state = st_done;
						end
						default: s_d.state = st_done;
					endcase
				end
			end
			st_done: begin
				if (!s_q.enable) begin
					s_d.state   = st_idle;
					s_d.capture = 1'b0;
				end
			end
			default: s_d.state = st_idle;
		endcase

		// Sample word tagged with trigger flag
		s_d.sample = sample_in;
		s_d.sample[FLAG_BIT] = s_q.trig_seen;

		if (wr) begin
			case (paddr)
				ADDR_CTRL: begin
					s_d.mode   = trig_mode_t'(pwdata[CTRL_MODE_LSB +: 3]);
					s_d.src    = trig_src_t'(pwdata[CTRL_SRC_LSB +: 3]);
					s_d.pol    = pwdata[CTRL_POL_BIT];
					s_d.enable = pwdata[CTRL_EN_BIT];
				end
				ADDR_LEVEL:   s_d.level = pwdata[LEVEL_W-1:0];
				ADDR_POSTCNT: s_d.cnt = pwdata[CNT_W-1:0];
				ADDR_IRQ_MSK: s_d.irq_msk = pwdata[2:0];
				default: ;
			endcase
		end

		// New events win over a write-one clear in the same cycle
		if (wr && (paddr == ADDR_IRQ_ST)) begin
			s_d.irq_st = (s_q.irq_st & ~pwdata[2:0]) | ev;
		end else begin
			s_d.irq_st = s_q.irq_st | ev;
		end

		if (rd) begin
			case (paddr)
				ADDR_CTRL: s_d.rdata = {19'h0, s_q.enable, 3'h0, s_q.pol,
				                        1'b0, s_q.src, 1'b0, s_q.mode};
				ADDR_LEVEL:   s_d.rdata = {24'h0, s_q.level};
				ADDR_POSTCNT: s_d.rdata = {16'h0, s_q.cnt};
				ADDR_STATUS:  s_d.rdata = {28'h0, s_q.capture, s_q.trig_seen, s_q.state};
				ADDR_IRQ_ST:  s_d.rdata = {29'h0, s_q.irq_st};
				ADDR_IRQ_MSK: s_d.rdata = {29'h0, s_q.irq_msk};
				default:      s_d.rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q.mode      <= mode_software;
			s_q.src       <= source_analog_input_0;
			s_q.pol       <= 1'b0;
			s_q.enable    <= 1'b0;
			s_q.level     <= LEVEL_RST;
			s_q.cnt       <= POSTCNT_RST;
			s_q.state     <= st_idle;
			s_q.trig_seen <= 1'b0;
			s_q.ext_prev  <= 1'b0;
			s_q.irq_st    <= IRQ_RST;
			s_q.irq_msk   <= IRQ_RST;
			s_q.rdata     <= 32'h0;
			s_q.sample    <= '0;
			s_q.capture   <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule

// ==== tb/trig_ctrl_properties.sv ====
// Checker for trig_ctrl: bus answers, sample path and post-trigger count reads.
// Assumes it is bound to trig_ctrl and sees only its ports.
`timescale 1ns/1ns
module trig_ctrl_properties
	import trig_pkg::*;
#(
	parameter int SAMPLE_W = 16
) (
	input wire logic                pclk,
	input wire logic                presetn,
	input wire logic                psel,
	input wire logic                penable,
	input wire logic                pwrite,
	input wire logic [7:0]          paddr,
	input wire logic [31:0]         pwdata,
	input wire logic [31:0]         prdata,
	input wire logic                pready,
	input wire logic                pslverr,
	input wire logic [SAMPLE_W-1:0] sample_in,
	input wire logic [SAMPLE_W-1:0] sample_out
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire acc    = psel && penable;
	wire rd_cnt = acc && !pwrite && paddr == ADDR_POSTCNT;
	wire wr_cnt = acc && pwrite && paddr == ADDR_POSTCNT;
	chk_ready_high: assert property (acc |-> pready) else $error("pready low");
	chk_unmapped_err: assert property (acc && paddr > ADDR_SWTRIG |-> pslverr
		&& (pwrite || prdata == 32'h0)) else $error("unmapped access not refused");
	chk_mapped_ok: assert property (acc && paddr <= ADDR_SWTRIG && paddr[1:0] == 2'h0
		|-> !pslverr) else $error("mapped access refused");
	chk_err_idle: assert property (!acc |-> !pslverr) else $error("pslverr outside access");
	chk_sample_data: assert property ($past(presetn) |->
		{sample_out[SAMPLE_W-1:4], sample_out[2:0]} ==
		$past({sample_in[SAMPLE_W-1:4], sample_in[2:0]})) else $error("sample bits lost");
	chk_count_load: assert property (wr_cnt ##3 rd_cnt |->
		prdata[15:0] == $past(pwdata[15:0], 3)) else $error("count not loaded");
	chk_zero_hold: assert property (rd_cnt && prdata[15:0] == 16'h0 ##3 rd_cnt |->
		prdata[15:0] == 16'h0) else $error("count left zero");
	chk_no_reload: assert property (rd_cnt ##3 rd_cnt |->
		prdata[15:0] <= $past(prdata[15:0], 3)) else $error("count rose without write");
endmodule

// ==== tb/acquisition_trigger_control_test.sv ====
// Bench for trig_ctrl: APB master, analog codes, external trigger, samples.
// Assumes a 10 MHz pclk and the checker bound below.
`timescale 1ns/1ns
module acquisition_trigger_control_test;
	import trig_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, ext_trig, last_err;
	logic [7:0]  paddr;
	logic [7:0]  ain [4];
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, capture_en, irq;
	logic [15:0] sample_in, sample_out;
	int          num_errors, check_count;
	trig_ctrl i_dut (.*, .ain_0(ain[0]), .ain_1(ain[1]), .ain_2(ain[2]), .ain_3(ain[3]));
	initial begin
		pclk = 0;
		forever #50 pclk = ~pclk;
	end
	always @(posedge pclk) sample_in <= presetn ? sample_in + 16'h1111 : 16'h0;
	task automatic chk(string n, logic [31:0] s, logic [31:0] e);
		check_count++;
		if (s !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] r);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		last_err = pslverr;
		psel <= 0;
		penable <= 0;
		// Idle cycle keeps one driver update per time step
		@(posedge pclk);
	endtask
	// Rising: active code sits exactly on the level, inactive one below it; falling swaps the two codes
	task automatic drv(int k, logic act, logic p);
		if (k == 4) ext_trig <= act ^ p;
		else ain[k] <= (act ^ p) ? 8'h40 : 8'h3f;
	endtask
	task automatic report_and_stop;
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic reset_state;
		logic [31:0] r;
		apb(0, ADDR_LEVEL, 0, r); chk("level", r, 32'h80);
		apb(0, ADDR_POSTCNT, 0, r); chk("count", r, 32'h0);
		apb(1, 8'h1c, 32'hffffffff, r); chk("wr err", last_err, 1);
		apb(0, 8'h1c, 0, r); chk("rd err", last_err, 1); chk("rd data", r, 0);
	endtask
	// Mode i (5 = post again), source rotates, polarity alternates
	task automatic run(int i);
		logic [2:0] m, s;
		logic p;
		logic [31:0] r, r2;
		m = (i < 5) ? 3'(i) : 3'h1; s = 3'((i + 4) % 5); p = i[0];
		for (int k = 0; k < 5; k++) drv(k, 0, p);
		apb(1, ADDR_POSTCNT, 32'h8, r); apb(0, ADDR_POSTCNT, 0, r); chk("load", r, 8);
		apb(1, ADDR_LEVEL, 32'h40, r); apb(1, ADDR_IRQ_MSK, 32'h1, r);
		apb(1, ADDR_CTRL, {19'h0, 1'b1, 3'h0, p, 1'b0, s, 1'b0, m}, r);
		for (int k = 0; k < 5; k++) if (k != s || m == mode_software) drv(k, 1, p);
		repeat (3) @(posedge pclk);
		chk("quiet", irq, 0);
		if (m == mode_software) apb(1, ADDR_SWTRIG, 32'h1, r);
		else begin
			drv(s, 1, p);
			// The hit is taken at the next edge, and its effects show right after that same edge
			@(posedge pclk);
		end
		@(posedge pclk);
		chk("irq", irq, 1);
		chk("capture", capture_en, m != mode_pre && m != delayed_capture_mode);
		apb(0, ADDR_POSTCNT, 0, r); apb(0, ADDR_POSTCNT, 0, r2);
		chk("step", r - r2, 3);
		repeat (12) @(posedge pclk);
		if (m >= delayed_capture_mode) chk("end", capture_en, m == delayed_capture_mode);
		chk("flag", sample_out[3], 1);
		apb(0, ADDR_POSTCNT, 0, r); chk("zero", r, 0);
		apb(0, ADDR_POSTCNT, 0, r); chk("held", r, 0);
		apb(1, ADDR_IRQ_ST, 32'h7, r); chk("cleared", irq, 0);
		apb(1, ADDR_CTRL, 0, r);
	endtask
	initial begin
		presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
		ext_trig = 0; ain = '{8'h0, 8'h0, 8'h0, 8'h0};
		num_errors = 0; check_count = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		reset_state();
		for (int i = 0; i < 6; i++) run(i);
		report_and_stop();
	end
	// Six runs take well under a thousand cycles
	initial begin
		#500000;
		num_errors++;
		report_and_stop();
	end
endmodule
bind trig_ctrl trig_ctrl_properties #(.SAMPLE_W(SAMPLE_W)) i_chk (.*);
